// ===== dspebp_mem.sv
// Far-side memory model for the three buses of the bus port.
// Assumes one shared acknowledge and word stores of 16 entries.
`timescale 1ns/1ps
module dspebp_mem
(
   input wire logic clock_i,
   input wire dspebp_pkg::dspebp_pins_t [2:0] pins_i,
   input wire logic [3:0] wait_i,
   output logic ack_n_o,
   output logic [2:0][15:0] lines_o
);
   // ***********************************
   // Storage and wait counting
   // ***********************************
   logic [15:0] mem [3][16]; // Word store, low address bits
   logic [3:0] cnt_ff = 4'h0; // Cycles with a strobe low
   logic [2:0][15:0] last_ff = '0; // Last wire level
   logic busy; // Some strobe is low
   initial
   begin
      foreach (mem[b, a]) mem[b][a] = 16'h0000;
   end
   // Any driven read or write strobe low
   always_comb
   begin
      busy = 1'b0;
      for (int b = 0; b < 3; b++)
         busy |= pins_i[b].ctl_oe & ~(pins_i[b].rd_n & pins_i[b].wr_n);
   end
   // Acknowledge only after the asked wait states
   assign ack_n_o = ~(busy && cnt_ff == wait_i);
   // Wire level: device data, read data, else a changing pattern
   always_comb
   begin
      for (int b = 0; b < 3; b++)
         if (pins_i[b].data_oe)
            lines_o[b] = pins_i[b].data;
         else if (pins_i[b].ctl_oe && !pins_i[b].rd_n)
            lines_o[b] = mem[b][pins_i[b].addr[3:0]];
         else
            lines_o[b] = ~last_ff[b];
   end
   // Count waits, store written words at the acknowledge edge
   always @(posedge clock_i)
   begin
      cnt_ff <= busy ? cnt_ff + 4'h1 : 4'h0;
      last_ff <= lines_o;
      for (int b = 0; b < 3; b++)
         if (!ack_n_o && pins_i[b].ctl_oe && !pins_i[b].wr_n)
            mem[b][pins_i[b].addr[3:0]] <= pins_i[b].data;
   end
endmodule

// ===== dspebp_pkg.sv
// Package for the external bus port of the signal processor core.
// Assumes a single core clock; shared by the bus port, the memory model and the bench.
package dspebp_pkg;

   // **********************************************************
   // Widths and reset values
   // **********************************************************
   localparam int ADDR_W = 16;                 // Address width per bus
   localparam int DATA_W = 16;                 // Data width per bus
   localparam logic [15:0] ADDR_RST = 16'h0000; // Address after reset
   localparam logic [15:0] DATA_RST = 16'h0000; // Data after reset
   localparam logic [1:0] BUS_X = 2'h0;        // X data bus index
   localparam logic [1:0] BUS_Y = 2'h1;        // Y data bus index
   localparam logic [1:0] BUS_P = 2'h2;        // Program bus index
   localparam int NBUS = 3;                    // Number of buses

   // **********************************************************
   // Port state machine
   // **********************************************************
   typedef enum logic [1:0] {
      DSPEBP_IDLE = 2'b00,   // No cycle running
      DSPEBP_XFER = 2'b01,   // Cycle running, waiting for acknowledge
      DSPEBP_HOLD = 2'b10    // Buses released to another master
   } dspebp_state_t;

   // Core request for one bus
   typedef struct packed {
      logic valid;              // Access wanted
      logic write;              // One for write, zero for read
      logic [15:0] addr;        // Word address
      logic [15:0] wdata;       // Data to write
   } dspebp_req_t;

   // Pin group of one bus, drive side
   typedef struct packed {
      logic [15:0] addr;        // Address lines
      logic [15:0] data;        // Data lines out
      logic data_oe;            // Data lines driven
      logic ctl_oe;             // Address and strobes driven
      logic rd_n;               // Read strobe
      logic wr_n;               // Write strobe
      logic cyc_n;              // Cycle strobe
   } dspebp_pins_t;

   // Per-bus register state
   typedef struct packed {
      logic active;             // Cycle in progress
      logic first;              // First cycle of bus cycle
      logic write;              // Direction of running cycle
      logic [15:0] addr;        // Latched address
      logic [15:0] wdata;       // Latched write data
      logic [15:0] rdata;       // Captured read data
   } dspebp_bus_t;

endpackage

// ===== dspebp_port.sv
// External bus port: X, Y and program buses with wait states and hold.
// Assumes the core holds its requests stable until done_o pulses.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - Data lines driven only during writes
// R2 - Read strobe low during read access
// R3 - Write strobe low during write access
// R4 - Cycle strobe low at cycle start
// R5 - Acknowledge sampled on rising clock edge
// R6 - Wait states until acknowledge is low
// R7 - Other master requests by hold low
// R8 - Hold stops core, floats address strobes
// R9 - Grant low only while buses float
// R10 - 64k program, 2x64k data word spaces
// R11 - Each bus has own 16-bit address
// R12 - Hold release resumes core and buses
module dspebp_port #(
   parameter int NB = dspebp_pkg::NBUS
)
(
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire dspebp_pkg::dspebp_req_t [2:0] req_i,
   output logic [2:0] done_o,
   output logic [2:0][15:0] rdata_o,
   output logic core_halt_o,
   input wire logic transfer_ack_n_i,
   input wire logic bus_hold_req_n_i,
   output logic bus_release_grant_n_o,
   output dspebp_pkg::dspebp_pins_t [2:0] pins_o,
   input wire logic [2:0][15:0] data_lines_i
);

   // **********************************************************
   // State
   // **********************************************************
   typedef struct packed {
      dspebp_pkg::dspebp_state_t st;         // Port state
      logic grant;                           // Hold granted
      logic [2:0] done;                      // Completion pulses
      dspebp_pkg::dspebp_bus_t [2:0] bus;    // Per-bus state
   } dspebp_all_t;

   dspebp_all_t cur_ff; // Registered state
   dspebp_all_t nxt_cur; // Next state
   logic any_req; // Some bus wants a cycle

   // Next state logic
   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.done = 3'h0;
      any_req = 1'b0;
      for (int i = 0; i < NB; i++)
      begin
         any_req = any_req | req_i[i].valid;
         nxt_cur.bus[i].first = 1'b0;
      end
      case (cur_ff.st)
         dspebp_pkg::DSPEBP_IDLE:
         begin
            // Hold has priority over a new cycle  [R7] [R8]
            if (!bus_hold_req_n_i)
            begin
               nxt_cur.st = dspebp_pkg::DSPEBP_HOLD;
            end
            else if (any_req)
            begin
               nxt_cur.st = dspebp_pkg::DSPEBP_XFER;
               for (int i = 0; i < NB; i++)
               begin
                  nxt_cur.bus[i].active = req_i[i].valid;
                  nxt_cur.bus[i].first = req_i[i].valid;
                  nxt_cur.bus[i].write = req_i[i].write;
                  nxt_cur.bus[i].addr = req_i[i].addr;
                  nxt_cur.bus[i].wdata = req_i[i].wdata;
               end
            end
         end
         dspebp_pkg::DSPEBP_XFER:
         begin
            // Acknowledge sampled each rising edge  [R5] [R6]
            if (!transfer_ack_n_i)
            begin
               nxt_cur.st = dspebp_pkg::DSPEBP_IDLE;
               for (int i = 0; i < NB; i++)
               begin
                  nxt_cur.done[i] = cur_ff.bus[i].active;
                  nxt_cur.bus[i].active = 1'b0;
                  if (cur_ff.bus[i].active && !cur_ff.bus[i].write)
                  begin
                     nxt_cur.bus[i].rdata = data_lines_i[i];
                  end
               end
            end
         end
         dspebp_pkg::DSPEBP_HOLD:
         begin
            // Grant follows floating buses; release resumes  [R9] [R12]
            nxt_cur.grant = !bus_hold_req_n_i;
            if (bus_hold_req_n_i)
            begin
               nxt_cur.st = dspebp_pkg::DSPEBP_IDLE;
            end
         end
         default:
         begin
            nxt_cur.st = dspebp_pkg::DSPEBP_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cur_ff <= '0;
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   // **********************************************************
   // Pin drive, one instance per bus
   // **********************************************************
   genvar g;
   generate
      for (g = 0; g < NB; g++)
      begin : g_bus
         // Address and strobes float in hold  [R8] [R11] [R10]
         assign pins_o[g].ctl_oe = (cur_ff.st != dspebp_pkg::DSPEBP_HOLD);
         assign pins_o[g].addr = cur_ff.bus[g].addr;
         // Strobes low only in running cycle  [R2] [R3]
         assign pins_o[g].rd_n = !(cur_ff.bus[g].active &&
                                   !cur_ff.bus[g].write);
         assign pins_o[g].wr_n = !(cur_ff.bus[g].active &&
                                   cur_ff.bus[g].write);
         // Cycle strobe marks the first cycle  [R4]
         assign pins_o[g].cyc_n = !cur_ff.bus[g].first;
         // Data driven only while writing  [R1]
         assign pins_o[g].data_oe = cur_ff.bus[g].active &&
                                    cur_ff.bus[g].write;
         assign pins_o[g].data = cur_ff.bus[g].wdata;
         assign rdata_o[g] = cur_ff.bus[g].rdata;
      end
   endgenerate

   assign done_o = cur_ff.done;
   assign core_halt_o = (cur_ff.st == dspebp_pkg::DSPEBP_HOLD); // [R8]
   assign bus_release_grant_n_o = !cur_ff.grant; // [R9]

   // **********************************************************
   // Assertions
   // **********************************************************
   property p_data_float; // [R1]
      @(posedge clock_i) disable iff (!arst_n_i)
      pins_o[0].data_oe |-> !pins_o[0].wr_n;
   endproperty
   a_data_float: assert property (p_data_float) // [R1]
      else $error("X data driven outside write");

   property p_rd; // [R2]
      @(posedge clock_i) disable iff (!arst_n_i)
      !pins_o[1].rd_n |-> !cur_ff.bus[1].write && pins_o[1].wr_n;
   endproperty
   a_rd: assert property (p_rd) // [R2]
      else $error("Read strobe with write");

   property p_wr; // [R3]
      @(posedge clock_i) disable iff (!arst_n_i)
      !pins_o[2].wr_n |-> pins_o[2].rd_n;
   endproperty
   a_wr: assert property (p_wr) // [R3]
      else $error("Both strobes low");

   property p_cyc; // [R4]
      @(posedge clock_i) disable iff (!arst_n_i)
      (cur_ff.st == dspebp_pkg::DSPEBP_IDLE && bus_hold_req_n_i
       && req_i[0].valid) |=> !pins_o[0].cyc_n ##1 pins_o[0].cyc_n;
   endproperty
   a_cyc: assert property (p_cyc) // [R4]
      else $error("Cycle strobe not one cycle at start");

   property p_wait; // [R6]
      @(posedge clock_i) disable iff (!arst_n_i)
      (cur_ff.st == dspebp_pkg::DSPEBP_XFER && transfer_ack_n_i)
      |=> cur_ff.st == dspebp_pkg::DSPEBP_XFER && done_o == 3'h0;
   endproperty
   a_wait: assert property (p_wait) // [R6]
      else $error("Cycle ended without acknowledge");

   property p_ack; // [R5]
      @(posedge clock_i) disable iff (!arst_n_i)
      (cur_ff.st == dspebp_pkg::DSPEBP_XFER && !transfer_ack_n_i
       && cur_ff.bus[0].active) |=> done_o[0];
   endproperty
   a_ack: assert property (p_ack) // [R5]
      else $error("Acknowledge not taken");

   property p_hold; // [R8]
      @(posedge clock_i) disable iff (!arst_n_i)
      !bus_release_grant_n_o |-> !pins_o[0].ctl_oe && !pins_o[1].ctl_oe
         && !pins_o[2].ctl_oe && core_halt_o;
   endproperty
   a_hold: assert property (p_hold) // [R8]
      else $error("Grant while buses driven");

   property p_grant; // [R9]
      @(posedge clock_i) disable iff (!arst_n_i)
      $fell(bus_release_grant_n_o) |-> $past(core_halt_o);
   endproperty
   a_grant: assert property (p_grant) // [R9]
      else $error("Grant before buses floated");

   property p_release; // [R12]
      @(posedge clock_i) disable iff (!arst_n_i)
      (core_halt_o && bus_hold_req_n_i) |=> !core_halt_o
         && bus_release_grant_n_o;
   endproperty
   a_release: assert property (p_release) // [R12]
      else $error("Hold not released");

   c_read: cover property (@(posedge clock_i) disable iff (!arst_n_i)
      !pins_o[0].rd_n ##1 done_o[0]);
   c_waits: cover property (@(posedge clock_i) disable iff (!arst_n_i)
      !pins_o[1].wr_n [*3] ##1 done_o[1]);
   c_holdgrant: cover property (@(posedge clock_i) disable iff (!arst_n_i)
      $fell(bus_release_grant_n_o));

endmodule

// ===== test_dspebp_port.sv
// Self-checking bench of the external bus port.
// Assumes dspebp_mem answers on the far side of all three buses.
`timescale 1ns/1ps
module test_dspebp_port;
   // ***********************************
   // Signals
   // ***********************************
   logic clock_i = 1'b0; // Core clock
   logic arst_n_i = 1'b0; // Reset, active low
   dspebp_pkg::dspebp_req_t [2:0] req = '0; // Core requests
   logic [2:0] done; // Cycle ends
   logic [2:0][15:0] rdata; // Read data
   logic halt; // Core stalled
   logic ack_n; // Shared acknowledge
   logic hold_n = 1'b1; // Hold request
   logic grant_n; // Hold grant
   dspebp_pkg::dspebp_pins_t [2:0] pins; // Pin groups
   logic [2:0][15:0] lines; // Data wires
   logic [3:0] wait_cnt = 4'h0; // Wait states asked
   int miscompares = 0;
   int check_count = 0;
   int seed = 32'hcf78b902;
   int ref_mem [3][16]; // Reference word store
   always #2.5 clock_i = ~clock_i;
   dspebp_port i_dspebp_port (.clock_i(clock_i), .arst_n_i(arst_n_i),
      .req_i(req), .done_o(done), .rdata_o(rdata), .core_halt_o(halt),
      .transfer_ack_n_i(ack_n), .bus_hold_req_n_i(hold_n),
      .bus_release_grant_n_o(grant_n), .pins_o(pins),
      .data_lines_i(lines));
   dspebp_mem i_dspebp_mem (.clock_i(clock_i), .pins_i(pins),
      .wait_i(wait_cnt), .ack_n_o(ack_n), .lines_o(lines));
   // ***********************************
   // Tasks
   // ***********************************
   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // One transfer on a random set of buses, optionally hit by hold
   task automatic xfer(input logic hold_mid, input logic last);
      int n;
      int w;
      logic [2:0] v;
      int exp_rd;
      w = hold_mid ? 3 : $unsigned($random(seed)) % 4;
      v = 3'($random(seed));
      if (v == 3'h0) v = 3'h4;
      wait_cnt = w[3:0];
      for (int b = 0; b < 3; b++)
         req[b] = {v[b], 1'($random(seed)), 32'($random(seed))};
      n = 0;
      // Done pulse of the previous call may still stand: step first
      do
      begin
         @(posedge clock_i);
         #1;
         n++;
         if (hold_mid && n == 1) hold_n = 1'b0;
         if (hold_mid) check(grant_n === 1'b1, "early grant");
         if (n == 1)
            for (int b = 0; b < 3; b++)
            begin
               check(pins[b].rd_n === ~(v[b] & ~req[b].write), "rd");
               check(pins[b].wr_n === ~(v[b] & req[b].write), "wr");
               check(pins[b].cyc_n === ~v[b], "cycle strobe");
               check(pins[b].data_oe === (v[b] & req[b].write), "oe");
               if (v[b])
                  check(pins[b].addr === req[b].addr, "addr");
            end
      end
      while (done === 3'h0 && n < 20);
      // No wait state: acknowledge is seen one edge after the take
      check(n == w + 2 && done === v, "wait states");
      for (int b = 0; b < 3; b++)
         if (v[b] && req[b].write)
            ref_mem[b][req[b].addr[3:0]] = req[b].wdata;
         else if (v[b])
         begin
            exp_rd = ref_mem[b][req[b].addr[3:0]];
            check(rdata[b] === 16'(exp_rd), "rd");
         end
      if (last) req = '0;
   endtask
   // Hold phase: requests refused, buses float, then released
   task automatic hold_phase();
      repeat (3)
      begin
         @(posedge clock_i);
         #1;
         check(done === 3'h0, "request in hold");
      end
      check(grant_n === 1'b0 && halt === 1'b1, "hold grant");
      for (int b = 0; b < 3; b++)
         check((pins[b].ctl_oe | pins[b].data_oe) === 1'b0, "float");
      hold_n = 1'b1;
      @(posedge clock_i);
      #1;
      check(grant_n === 1'b1 && halt === 1'b0, "release");
      check(pins[2].ctl_oe === 1'b1, "drive again");
   endtask
   // ***********************************
   // Main sequence and watchdog
   // ***********************************
   initial
   begin
      repeat (12) @(posedge clock_i);
      #1 arst_n_i = 1'b1;
      check(grant_n === 1'b1 && pins[0].cyc_n === 1'b1, "reset");
      // Back to back: the hold call below replaces the last request
      for (int i = 0; i < 40; i++) xfer(1'b0, 1'b0);
      xfer(1'b1, 1'b1);
      hold_phase();
      @(posedge clock_i);
      #1;
      hold_n = 1'b0;
      req[1] = {1'b1, 1'b0, 32'($random(seed))};
      hold_phase();
      // Sample off the edge so the done pulse is seen settled
      for (int n = 0; n < 10 && done === 3'h0; n++)
      begin
         @(posedge clock_i);
         #1;
      end
      check(done === 3'h2, "resume done");
      check(rdata[1] === 16'(ref_mem[1][req[1].addr[3:0]]), "resume");
      req = '0;
      close_out();
   end
   initial
   begin
      #20000;
      miscompares++;
      close_out();
   end
endmodule
